// ### verilog/hgp_pkg.sv
package hgp_pkg;

  // bus geometry
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned NPIN = 8;
  localparam int unsigned NRX = 4;
  localparam int unsigned NTX = 2;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SNAPSHOT = 8'h0E;
  localparam logic [7:0] IDX_INPUT_MASK = 8'h0F;
  localparam logic [7:0] IDX_PIN0_CTL = 8'h10;

  // reset values
  localparam logic [7:0] SNAPSHOT_RST = 8'h00;
  localparam logic [7:0] INPUT_MASK_RST = 8'hFF;
  localparam logic [7:0] PIN0_CTL_RST = 8'h00;

  // pin0 control field positions
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_VAL_BIT = 1;
  localparam int unsigned CTL_SRC_LSB = 2;
  localparam int unsigned CTL_SEL_LSB = 5;

  // source field codes
  localparam logic [2:0] SRC_DEV_STATUS = 3'h4;
  localparam logic [2:0] SRC_RESERVED = 3'h5;

  // receive port selections
  localparam logic [2:0] RXS_LOCK = 3'h4;
  localparam logic [2:0] RXS_PASS = 3'h5;
  localparam logic [2:0] RXS_FRAME = 3'h6;
  localparam logic [2:0] RXS_LINE = 3'h7;

  // device status selections
  localparam logic [2:0] DEVS_VALUE = 3'h0;
  localparam logic [2:0] DEVS_LOCK_ANY = 3'h1;
  localparam logic [2:0] DEVS_LOCK_ALL = 3'h2;
  localparam logic [2:0] DEVS_PASS_ALL = 3'h3;
  localparam logic [2:0] DEVS_FSYNC = 3'h4;

  // transmit port selections
  localparam logic [2:0] TXS_PASS_ALL = 3'h0;
  localparam logic [2:0] TXS_PASS_ANY = 3'h1;
  localparam logic [2:0] TXS_FRAME = 3'h2;
  localparam logic [2:0] TXS_LINE = 3'h3;
  localparam logic [2:0] TXS_SYNCED = 3'h4;
  localparam logic [2:0] TXS_IRQ = 3'h5;

endpackage : hgp_pkg

// ### verilog/hgp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a vector of unrelated levels
module hgp_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : hgp_sync

// ### verilog/hgp_gpio.sv
`timescale 1ns/1ps
// Behaviour
// - a read of the snapshot register returns the eight pin levels gated by their input enables, pin 7 on top.
// - each pin has an input-enable bit at its own position, 1 enables, all reset to 1.
// - source field bits 4:2 pick rx port 0-3, device status, reserved, or tx port 0-1.
// - select field bits 7:5 is read according to the source class chosen.
// - for an rx source, selects 000-011 give remote pin values 0-3 of that port.
// - for an rx source, 100 gives lock, 101 gives pass and 111 gives line valid.
// - for an rx source, 110 gives that port's frame valid.
// - for device status, 000 gives the stored value bit and 001 the OR of enabled locks.
// - for device status, 010 ANDs enabled locks, 011 ANDs enabled passes, 100 frame sync.
// - for a tx source, 000 ANDs and 001 ORs the status of its selected rx ports.
// - for a tx source, 011 line valid, 100 synchronised flag, 101 port interrupt.
// - for a tx source, 010 gives frame valid.
// - bit 1 of the pin0 control register is the level driven when the stored value is chosen.
// - bit 0 of the pin0 control register enables the pin0 driver and resets to 0.
module hgp_gpio (
  input wire logic clock_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [hgp_pkg::APB_AW-1:0] paddr_in,
  input wire logic [hgp_pkg::APB_DW-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [hgp_pkg::APB_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pins
  input wire logic [hgp_pkg::NPIN-1:0] pin_level_in,
  output logic pin0_out,
  output logic pin0_oe_out,
  // receive port status, same clock
  input wire logic [4*hgp_pkg::NRX-1:0] rx_remote_pin_in,
  input wire logic [hgp_pkg::NRX-1:0] rx_port_enable_in,
  input wire logic [hgp_pkg::NRX-1:0] rx_lock_in,
  input wire logic [hgp_pkg::NRX-1:0] rx_pass_in,
  input wire logic [hgp_pkg::NRX-1:0] rx_frame_valid_in,
  input wire logic [hgp_pkg::NRX-1:0] rx_line_valid_in,
  input wire logic frame_sync_pulse_in,
  // transmit port status, same clock
  input wire logic [hgp_pkg::NRX*hgp_pkg::NTX-1:0] tx_rx_select_in,
  input wire logic [hgp_pkg::NTX-1:0] tx_frame_valid_in,
  input wire logic [hgp_pkg::NTX-1:0] tx_line_valid_in,
  input wire logic [hgp_pkg::NTX-1:0] tx_synced_in,
  input wire logic [hgp_pkg::NTX-1:0] tx_irq_in
);
  import hgp_pkg::*;

  // all set among enabled bits; false when none enabled
  function automatic logic all_of(input logic [NRX-1:0] v, input logic [NRX-1:0] en);
    all_of = (en != '0) && ((v & en) == en);
  endfunction : all_of

  // any set among enabled bits
  function automatic logic any_of(input logic [NRX-1:0] v, input logic [NRX-1:0] en);
    any_of = |(v & en);
  endfunction : any_of

  // byte address from printed index
  function automatic logic [APB_AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {{(APB_AW-10){1'b0}}, idx, 2'b00};
  endfunction : byte_addr

  logic [NPIN-1:0] pin_sync;
  logic [7:0] input_mask_q;
  logic [7:0] pin0_ctl_q;
  logic [7:0] snapshot_q;
  logic [7:0] snapshot_d;
  logic [APB_DW-1:0] prdata_q;
  logic pin0_q;
  logic pin0_d;
  logic [2:0] src;
  logic [2:0] sel;
  logic [1:0] rx_idx;
  logic tx_idx;
  logic [NRX-1:0] tx_mask;
  logic hit_snap;
  logic hit_mask;
  logic hit_ctl;
  logic mapped;
  logic setup;
  logic access;
  logic wr_ok;

  // pin levels cross into the clock domain
  hgp_sync #(.W(NPIN)) u_pin_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(pin_level_in),
    .sync_out(pin_sync)
  );

  // address decode and phases
  assign hit_snap = (paddr_in == byte_addr(IDX_SNAPSHOT));
  assign hit_mask = (paddr_in == byte_addr(IDX_INPUT_MASK));
  assign hit_ctl = (paddr_in == byte_addr(IDX_PIN0_CTL));
  assign mapped = hit_snap | hit_mask | hit_ctl;
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign wr_ok = access & pwrite_in & pstrb_in[0];

  // zero wait states; unmapped address answers with an error
  assign pready_out = 1'b1;
  assign pslverr_out = access & ~mapped;
  assign prdata_out = prdata_q;

  // gated pin levels; a disabled input reads 0
  assign snapshot_d = pin_sync & input_mask_q;

  // snapshot register follows the gated pins
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      snapshot_q <= SNAPSHOT_RST;
    end else begin
      snapshot_q <= snapshot_d;
    end
  end

  // input enable mask
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      input_mask_q <= INPUT_MASK_RST;
    end else if (wr_ok && hit_mask) begin
      input_mask_q <= pwdata_in[7:0];
    end
  end

  // pin0 control register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin0_ctl_q <= PIN0_CTL_RST;
    end else if (wr_ok && hit_ctl) begin
      pin0_ctl_q <= pwdata_in[7:0];
    end
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata_q <= '0;
    end else if (setup && !pwrite_in) begin
      if (hit_snap) begin
        prdata_q <= {24'h000000, snapshot_q};
      end else if (hit_mask) begin
        prdata_q <= {24'h000000, input_mask_q};
      end else if (hit_ctl) begin
        prdata_q <= {24'h000000, pin0_ctl_q};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // field extraction
  assign src = pin0_ctl_q[CTL_SRC_LSB +: 3];
  assign sel = pin0_ctl_q[CTL_SEL_LSB +: 3];
  assign rx_idx = src[1:0];
  assign tx_idx = src[0];
  assign tx_mask = tx_rx_select_in[tx_idx*NRX +: NRX];

  // pin0 signal mux by source class then select
  always_comb begin
    pin0_d = 1'b0;
    if (!src[2]) begin
      case (sel)
        RXS_LOCK: pin0_d = rx_lock_in[rx_idx];
        RXS_PASS: pin0_d = rx_pass_in[rx_idx];
        RXS_FRAME: pin0_d = rx_frame_valid_in[rx_idx];
        RXS_LINE: pin0_d = rx_line_valid_in[rx_idx];
        default: pin0_d = rx_remote_pin_in[{rx_idx, sel[1:0]}];
      endcase
    end else if (src == SRC_DEV_STATUS) begin
      case (sel)
        DEVS_VALUE: pin0_d = pin0_ctl_q[CTL_VAL_BIT];
        DEVS_LOCK_ANY: pin0_d = any_of(rx_lock_in, rx_port_enable_in);
        DEVS_LOCK_ALL: pin0_d = all_of(rx_lock_in, rx_port_enable_in);
        DEVS_PASS_ALL: pin0_d = all_of(rx_pass_in, rx_port_enable_in);
        DEVS_FSYNC: pin0_d = frame_sync_pulse_in;
        default: pin0_d = 1'b0;
      endcase
    end else if (src != SRC_RESERVED) begin
      case (sel)
        TXS_PASS_ALL: pin0_d = all_of(rx_pass_in, tx_mask);
        TXS_PASS_ANY: pin0_d = any_of(rx_pass_in, tx_mask);
        TXS_FRAME: pin0_d = tx_frame_valid_in[tx_idx];
        TXS_LINE: pin0_d = tx_line_valid_in[tx_idx];
        TXS_SYNCED: pin0_d = tx_synced_in[tx_idx];
        TXS_IRQ: pin0_d = tx_irq_in[tx_idx];
        default: pin0_d = 1'b0;
      endcase
    end
  end

  // registered pin0 data, forced low while undriven
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin0_q <= 1'b0;
    end else begin
      pin0_q <= pin0_d & pin0_ctl_q[CTL_EN_BIT];
    end
  end

  assign pin0_out = pin0_q;
  assign pin0_oe_out = pin0_ctl_q[CTL_EN_BIT];

  // snapshot read returns gated levels seen two edges earlier
  property p_snap_read;
    @(posedge clock_in) disable iff (rst_in)
    (setup && !pwrite_in && hit_snap) ##1 access |->
      prdata_out[7:0] == $past(snapshot_d, 2) && prdata_out[31:8] == 24'h000000;
  endproperty
  a_snap_read: assert property (p_snap_read) else $error("snapshot read mismatch");

  // input mask comes out of reset all ones
  property p_mask_reset;
    @(posedge clock_in)
    $past(rst_in) |-> input_mask_q == 8'hFF;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("input mask reset wrong");

  // pin0 input disabled on two successive edges does not show in the snapshot
  property p_mask_gate;
    @(posedge clock_in) disable iff (rst_in)
    !input_mask_q[0] ##1 !input_mask_q[0] |-> !snapshot_q[0];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("disabled pin0 input visible");

  // driver enable resets off and follows a write one edge later
  property p_oe_write;
    @(posedge clock_in) disable iff (rst_in)
    (wr_ok && hit_ctl) |=> pin0_oe_out == $past(pwdata_in[0]);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("pin0 enable not updated");

  // undriven pin0 is held low on its data line
  property p_oe_off;
    @(posedge clock_in) disable iff (rst_in)
    !pin0_oe_out ##1 !pin0_oe_out |-> !pin0_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin0 data while undriven");

  // stored value drives pin0 under device status select 000
  property p_value;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h4 && sel == 3'h0) |=> pin0_out == $past(pin0_ctl_q[1]);
  endproperty
  a_value: assert property (p_value) else $error("stored value not driven");

  // rx port lock reaches pin0 one edge later
  property p_rx_lock;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h2 && sel == 3'h4) |=> pin0_out == $past(rx_lock_in[2]);
  endproperty
  a_rx_lock: assert property (p_rx_lock) else $error("rx lock not driven");

  // rx port frame valid
  property p_rx_frame;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h1 && sel == 3'h6) |=> pin0_out == $past(rx_frame_valid_in[1]);
  endproperty
  a_rx_frame: assert property (p_rx_frame) else $error("rx frame valid not driven");

  // remote pin value of port 3, pin 2
  property p_remote;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h3 && sel == 3'h2) |=> pin0_out == $past(rx_remote_pin_in[14]);
  endproperty
  a_remote: assert property (p_remote) else $error("remote pin not driven");

  // device status lock any
  property p_lock_any;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h4 && sel == 3'h1) |=>
      pin0_out == |($past(rx_lock_in) & $past(rx_port_enable_in));
  endproperty
  a_lock_any: assert property (p_lock_any) else $error("lock or wrong");

  // device status frame sync
  property p_fsync;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h4 && sel == 3'h4) |=> pin0_out == $past(frame_sync_pulse_in);
  endproperty
  a_fsync: assert property (p_fsync) else $error("frame sync not driven");

  // reserved source keeps pin0 low
  property p_src_rsvd;
    @(posedge clock_in) disable iff (rst_in)
    (src == 3'h5) |=> !pin0_out;
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("reserved source drove pin0");

  // tx port 1 interrupt
  property p_tx_irq;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h7 && sel == 3'h5) |=> pin0_out == $past(tx_irq_in[1]);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt not driven");

  // tx port 0 frame valid
  property p_tx_frame;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h6 && sel == 3'h2) |=> pin0_out == $past(tx_frame_valid_in[0]);
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("tx frame valid not driven");

  // tx port 0 pass any of its selected ports
  property p_tx_pass_any;
    @(posedge clock_in) disable iff (rst_in)
    (pin0_oe_out && src == 3'h6 && sel == 3'h1) |=>
      pin0_out == |($past(rx_pass_in) & $past(tx_rx_select_in[3:0]));
  endproperty
  a_tx_pass_any: assert property (p_tx_pass_any) else $error("tx pass or wrong");

endmodule : hgp_gpio

// ### dv/hgp_pin_board.sv
`timescale 1ns/1ps
// board wiring around the eight pins; pin0 is shared with the device driver
module hgp_pin_board (
  input wire logic [7:0] board_level_in,
  input wire logic pin0_in,
  input wire logic pin0_oe_in,
  output logic [7:0] pin_level_out
);
  // pins 1-7 follow the board; pin0 follows the device only while it drives
  assign pin_level_out = {board_level_in[7:1], pin0_oe_in ? pin0_in : board_level_in[0]};
endmodule : hgp_pin_board

// ### dv/hub_gpio_pin_control_tb_top.sv
`timescale 1ns/1ps
module hub_gpio_pin_control_tb_top;
  import hgp_pkg::*;
  localparam logic [11:0] A_SNAP = {2'b00, IDX_SNAPSHOT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, IDX_INPUT_MASK, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_PIN0_CTL, 2'b00};
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata;
  logic [APB_DW-1:0] rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, pin0, pin0_oe, err;
  logic [7:0] board_lvl = 8'h00;
  logic [7:0] pins;
  logic [15:0] rx_rem = '0;
  logic [3:0] rx_en = '0, rx_lock = '0, rx_pass = '0, rx_fv = '0, rx_lv = '0;
  logic fsync = 1'b0;
  logic [7:0] tx_sel = '0;
  logic [1:0] tx_fv = '0, tx_lv = '0, tx_sy = '0, tx_irq = '0;
  int fails = 0;
  int n_compared = 0;

  // free-running core clock, 50 ns period
  always #25 clock_in = ~clock_in;

  hgp_pin_board board (.board_level_in(board_lvl), .pin0_in(pin0), .pin0_oe_in(pin0_oe),
    .pin_level_out(pins));

  hgp_gpio dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pin_level_in(pins),
    .pin0_out(pin0), .pin0_oe_out(pin0_oe), .rx_remote_pin_in(rx_rem),
    .rx_port_enable_in(rx_en), .rx_lock_in(rx_lock), .rx_pass_in(rx_pass),
    .rx_frame_valid_in(rx_fv), .rx_line_valid_in(rx_lv), .frame_sync_pulse_in(fsync),
    .tx_rx_select_in(tx_sel), .tx_frame_valid_in(tx_fv), .tx_line_valid_in(tx_lv),
    .tx_synced_in(tx_sy), .tx_irq_in(tx_irq));

  // verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // compare one value against its expectation
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] st);
    int n;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge clock_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // read a register and check data and error flag
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
    input logic exp_err);
    apb(1'b0, a, 8'h00, 4'h0);
    chk(nm, rd, exp);
    chk("pslverr", 32'(err), 32'(exp_err));
  endtask : rd_chk

  // expected pin0 level for a control byte and the present status inputs
  function automatic logic exp_pin0(input logic [7:0] c);
    logic [2:0] s;
    logic [3:0] m;
    int p;
    s = c[7:5];
    p = int'(c[3:2]);
    m = c[2] ? tx_sel[7:4] : tx_sel[3:0];
    if (c[0] !== 1'b1) return 1'b0;
    if (!c[4]) begin
      case (s)
        RXS_LOCK: return rx_lock[p];
        RXS_PASS: return rx_pass[p];
        RXS_FRAME: return rx_fv[p];
        RXS_LINE: return rx_lv[p];
        default: return rx_rem[4*p + int'(s[1:0])];
      endcase
    end
    if (c[4:2] == SRC_DEV_STATUS) begin
      case (s)
        DEVS_VALUE: return c[1];
        DEVS_LOCK_ANY: return |(rx_lock & rx_en);
        DEVS_LOCK_ALL: return (rx_en != 0) && ((rx_lock & rx_en) == rx_en);
        DEVS_PASS_ALL: return (rx_en != 0) && ((rx_pass & rx_en) == rx_en);
        DEVS_FSYNC: return fsync;
        default: return 1'b0;
      endcase
    end
    if (c[4:2] == SRC_RESERVED) return 1'b0;
    case (s)
      TXS_PASS_ALL: return (m != 0) && ((rx_pass & m) == m);
      TXS_PASS_ANY: return |(rx_pass & m);
      TXS_FRAME: return tx_fv[c[2]];
      TXS_LINE: return tx_lv[c[2]];
      TXS_SYNCED: return tx_sy[c[2]];
      TXS_IRQ: return tx_irq[c[2]];
      default: return 1'b0;
    endcase
  endfunction : exp_pin0

  // bound on the whole run
  initial begin
    repeat (100000) @(posedge clock_in);
    fails++;
    wrap_up();
  end

  // main sequence
  initial begin
    logic [7:0] lvl, msk, c;
    void'($urandom(83));
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_chk("mask_rst", A_MASK, 32'hFF, 1'b0);
    rd_chk("ctl_rst", A_CTL, 32'h0, 1'b0);
    chk("oe_rst", 32'(pin0_oe), 32'h0);
    rd_chk("unmapped", 12'h044, 32'h0, 1'b1);
    // snapshot against live levels and input mask, incl. all-off and all-on
    for (int i = 0; i < 10; i++) begin
      lvl = 8'($urandom);
      msk = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      board_lvl <= lvl;
      apb(1'b1, A_MASK, msk, 4'hF);
      apb(1'b1, A_SNAP, ~lvl, 4'hF);
      repeat (4) @(posedge clock_in);
      rd_chk("snapshot", A_SNAP, {24'h0, lvl & msk}, 1'b0);
    end
    apb(1'b1, A_MASK, ~msk, 4'hE);
    rd_chk("mask_nostrb", A_MASK, {24'h0, msk}, 1'b0);
    apb(1'b1, A_MASK, 8'hFF, 4'hF);
    // every source and select code with random status
    for (int k = 0; k < 64; k++) begin
      rx_rem <= 16'($urandom);
      {rx_en, rx_lock, rx_pass, rx_fv, rx_lv} <= 20'($urandom);
      {fsync, tx_sel, tx_fv, tx_lv, tx_sy, tx_irq} <= 17'($urandom);
      @(posedge clock_in);
      c = {k[2:0], k[5:3], 1'($urandom), 1'b1};
      apb(1'b1, A_CTL, c, 4'hF);
      repeat (4) @(posedge clock_in);
      chk("pin0", 32'(pin0), 32'(exp_pin0(c)));
      chk("pin0_oe", 32'(pin0_oe), 32'h1);
      rd_chk("ctl_rb", A_CTL, {24'h0, c}, 1'b0);
    end
    // driver off: pin undriven, outside level reported
    board_lvl <= 8'h01;
    apb(1'b1, A_CTL, 8'h10, 4'hF);
    repeat (4) @(posedge clock_in);
    chk("oe_off", 32'(pin0_oe), 32'h0);
    chk("pin0_off", 32'(pin0), 32'h0);
    rd_chk("snap_ext", A_SNAP, 32'h01, 1'b0);
    // driver on with stored value 1 while the board holds 0
    board_lvl <= 8'h00;
    apb(1'b1, A_CTL, 8'h13, 4'hF);
    repeat (4) @(posedge clock_in);
    rd_chk("snap_drv", A_SNAP, 32'h01, 1'b0);
    wrap_up();
  end
endmodule : hub_gpio_pin_control_tb_top
